/* hw/wsc_pkg.sv */
// package for the watchdog and power-down controller
// assumes a 100 MHz core clock and a free-running watchdog tick input
package wsc_pkg;

  // ----------------------------------------------------------------------
  // register map of the plain register port
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_OPTION = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_CONFIG = 4'h2;
  localparam logic [3:0] ADDR_IRQ = 4'h3;
  localparam logic [15:0] CONFIG_WORD_ADDR = 16'h2007;
  localparam logic [7:0] OPTION_RESET = 8'hFF;

  // option register field positions
  localparam int OPT_PS_LO = 0;
  localparam int OPT_PSA = 3;
  // configuration word field positions
  localparam int CFG_WATCHDOG_ENABLE_CFG = 2;
  localparam int CFG_OSC = 0;
  // status bit positions
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  // irq control bit position of the global enable
  localparam int IRQ_GIE = 7;
  localparam logic [10:0] IRQ_VECTOR = 11'h004;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int WDT_PERIOD_MS = 18;
  localparam int WDT_TICK_KHZ = 32;
  localparam int WDT_BASE_TICKS = WDT_PERIOD_MS * WDT_TICK_KHZ;
  localparam int OST_OSC_PERIODS = 1024;

  // sleep sequencer states, gray on every step of the usual path except start back to run
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_START = 2'b11
  } wsc_state_type;

  // instruction events from the sequencer
  typedef struct packed {
    logic clear_wdt;
    logic sleep;
  } wsc_instr_type;

  // wake and reset requests to the sequencer
  typedef struct packed {
    logic wdt_reset;
    logic resume;
    logic vector;
  } wsc_ctrl_type;

endpackage : wsc_pkg

/* hw/wsc_watchdog_sleep.sv */
// watchdog timer, prescaler and power-down controller
// assumes sequencer pulses for instructions and a same-clock irq status
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
module wsc_watchdog_sleep #(
  parameter int BASE_TICKS = wsc_pkg::WDT_BASE_TICKS,
  parameter int OST_CYCLES = wsc_pkg::OST_OSC_PERIODS,
  parameter int IRQ_W = 12,
  parameter int PORT_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic wdt_osc_i,
  input wire logic master_clear_n_i,
  input wire logic [7:0] device_configuration_word_i,
  input wire wsc_pkg::wsc_instr_type instr_i,
  input wire logic [IRQ_W-1:0] irq_flag_i,
  input wire logic [IRQ_W-1:0] irq_enable_i,
  input wire logic [IRQ_W-1:0] irq_wake_capable_i,
  input wire logic [PORT_W-1:0] port_out_i,
  input wire logic [PORT_W-1:0] port_oe_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output wsc_pkg::wsc_ctrl_type ctrl_o,
  output logic osc_run_o,
  output logic [PORT_W-1:0] port_out_o,
  output logic [PORT_W-1:0] port_oe_o,
  output logic timeout_status_n_o,
  output logic powerdown_status_n_o,
  output logic [10:0] vector_o
);
  import wsc_pkg::*;

  localparam int BW = $clog2(BASE_TICKS + 1);
  localparam int OW = $clog2(OST_CYCLES + 1);

  // ----------------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------------
  logic [7:0] option_control_q;
  logic [7:0] irq_control_reg_q;
  logic [7:0] cfg_q;
  logic cfg_seen_q;
  logic [BW-1:0] watchdog_counter_q;
  logic [6:0] prescale_q;
  logic [2:0] tick_sync_q;
  logic timeout_status_n_q;
  logic powerdown_status_n_q;
  wsc_state_type state_q;
  logic [OW-1:0] ost_q;
  logic [1:0] master_clear_n_sync_q;
  logic vector_pend_q;

  // decoded controls
  logic watchdog_enable_cfg;
  logic external_clock_mode;
  logic prescaler_assign;
  logic [2:0] prescale_sel;
  logic tick;
  logic base_tc;
  logic expire;
  logic clear_wdt;
  logic sleep_exec;
  logic irq_pending;
  logic irq_wake;

  // prescaler terminal count for a 1:2^(sel+1) division
  function automatic logic pre_tc(input logic [6:0] cnt,
                                  input logic [2:0] sel);
    logic [6:0] mask;
    // select 7 saturates at the 1:128 ceiling instead of wrapping
    mask = (sel == 3'h7) ? 7'h7F : 7'h7F >> (3'h6 - sel);
    return (cnt & mask) == mask;
  endfunction

  assign watchdog_enable_cfg = cfg_q[CFG_WATCHDOG_ENABLE_CFG];
  assign external_clock_mode = cfg_q[CFG_OSC];
  assign prescaler_assign = option_control_q[OPT_PSA];
  assign prescale_sel = option_control_q[OPT_PS_LO +: 3];

  // ----------------------------------------------------------------------
  // synchronisers for the watchdog tick and master clear
  // ----------------------------------------------------------------------
  // tick edge from the dedicated oscillator
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_sync_q <= 3'h0;
    end else if (ce_i) begin
      tick_sync_q <= {tick_sync_q[1:0], wdt_osc_i};
    end
  end
  assign tick = tick_sync_q[2] ^ tick_sync_q[1];

  // master clear pin
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      master_clear_n_sync_q <= 2'h3;
    end else if (ce_i) begin
      master_clear_n_sync_q <= {master_clear_n_sync_q[0], master_clear_n_i};
    end
  end

  // configuration word caught after reset release
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_q <= 8'h00;
      cfg_seen_q <= 1'b0;
    end else if (ce_i && !cfg_seen_q) begin
      cfg_q <= device_configuration_word_i;
      cfg_seen_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------------
  assign irq_pending = |(irq_flag_i & irq_enable_i & irq_wake_capable_i);
  assign irq_wake = irq_pending;
  // sleep with an enabled, wake-capable irq already pending acts as a no-op
  assign sleep_exec = instr_i.sleep && state_q == ST_RUN
                      && !irq_pending;
  assign clear_wdt = instr_i.clear_wdt || sleep_exec;

  // ----------------------------------------------------------------------
  // watchdog base counter and prescaler
  // ----------------------------------------------------------------------
  assign base_tc = tick && watchdog_counter_q == BW'(BASE_TICKS - 1);
  assign expire = cfg_seen_q && watchdog_enable_cfg && base_tc
                  && (!prescaler_assign || pre_tc(prescale_q, prescale_sel));

  // base counter runs on ticks in every state
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      watchdog_counter_q <= '0;
    end else if (ce_i) begin
      if (clear_wdt || !watchdog_enable_cfg) begin
        watchdog_counter_q <= '0;
      end else if (base_tc) begin
        watchdog_counter_q <= '0;
      end else if (tick) begin
        watchdog_counter_q <= BW'(watchdog_counter_q + 1'b1);
      end
    end
  end

  // prescaler counts base terminal counts when assigned
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prescale_q <= 7'h00;
    end else if (ce_i) begin
      if (clear_wdt) begin
        prescale_q <= 7'h00;
      end else if (base_tc && prescaler_assign) begin
        prescale_q <= pre_tc(prescale_q, prescale_sel) ? 7'h00
                      : 7'(prescale_q + 1'b1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  // option and irq control writes; assignment only changes on write
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      option_control_q <= OPTION_RESET;
      irq_control_reg_q <= 8'h00;
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i == ADDR_OPTION) begin
        option_control_q <= reg_wdata_i;
      end
      if (reg_addr_i == ADDR_IRQ) begin
        irq_control_reg_q <= reg_wdata_i;
      end
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      reg_rdata_o <= 8'h00;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          ADDR_OPTION: reg_rdata_o <= option_control_q;
          ADDR_STATUS: reg_rdata_o <= {3'h0, timeout_status_n_q,
                                       powerdown_status_n_q, 3'h0};
          ADDR_CONFIG: reg_rdata_o <= cfg_q;
          ADDR_IRQ: reg_rdata_o <= irq_control_reg_q;
          default: reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // status bits
  // ----------------------------------------------------------------------
  // expiry wins over sleep setting time-out
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      timeout_status_n_q <= 1'b1;
      powerdown_status_n_q <= 1'b1;
    end else if (ce_i) begin
      if (expire) begin
        timeout_status_n_q <= 1'b0;
      end else if (sleep_exec) begin
        timeout_status_n_q <= 1'b1;
      end
      if (sleep_exec) begin
        powerdown_status_n_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // sleep sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_q <= ST_RUN;
      ost_q <= '0;
    end else if (ce_i) begin
      unique case (state_q)
        ST_RUN: begin
          if (sleep_exec) begin
            state_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (master_clear_n_sync_q[1] && (expire || irq_wake)) begin
            if (external_clock_mode) begin
              state_q <= ST_RUN;
            end else begin
              state_q <= ST_START;
              ost_q <= OW'(OST_CYCLES - 1);
            end
          end
        end
        ST_START: begin
          if (ost_q == '0) begin
            state_q <= ST_RUN;
          end else begin
            ost_q <= OW'(ost_q - 1'b1);
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // outputs to the sequencer and pins
  // ----------------------------------------------------------------------
  // remember whether the wake should branch to the vector
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      vector_pend_q <= 1'b0;
    end else if (ce_i) begin
      if (state_q == ST_SLEEP && irq_wake && !expire) begin
        vector_pend_q <= irq_control_reg_q[IRQ_GIE];
      end else if (state_q == ST_RUN) begin
        vector_pend_q <= 1'b0;
      end
    end
  end

  // registered control pulses
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_o <= '0;
      osc_run_o <= 1'b1;
      vector_o <= IRQ_VECTOR;
    end else if (ce_i) begin
      ctrl_o.wdt_reset <= expire && state_q == ST_RUN;
      ctrl_o.resume <= state_q != ST_RUN && state_q != ST_SLEEP
                       ? ost_q == '0
                       : (state_q == ST_SLEEP && master_clear_n_sync_q[1]
                          && (expire || irq_wake) && external_clock_mode);
      ctrl_o.vector <= (state_q == ST_RUN) && irq_pending
                       && irq_control_reg_q[IRQ_GIE];
      osc_run_o <= !(sleep_exec || state_q == ST_SLEEP);
      vector_o <= IRQ_VECTOR;
    end
  end

  // pins frozen while asleep
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      port_out_o <= '0;
      port_oe_o <= '0;
    end else if (ce_i && state_q == ST_RUN && !sleep_exec) begin
      port_out_o <= port_out_i;
      port_oe_o <= port_oe_i;
    end
  end

  // status bits to pins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      timeout_status_n_o <= 1'b1;
      powerdown_status_n_o <= 1'b1;
    end else if (ce_i) begin
      timeout_status_n_o <= timeout_status_n_q;
      powerdown_status_n_o <= powerdown_status_n_q;
    end
  end

  logic unused_vec;
  assign unused_vec = vector_pend_q;

endmodule // wsc_watchdog_sleep

/* tb/wsc_properties.sv */
// port checker for the watchdog and sleep controller
// assumes a bind onto the controller top module
`timescale 1ns/1ns
module wsc_properties import wsc_pkg::*; #(
  parameter int IRQ_W = 12,
  parameter int PORT_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic master_clear_n_i,
  input wire logic [7:0] device_configuration_word_i,
  input wire wsc_pkg::wsc_instr_type instr_i,
  input wire logic [IRQ_W-1:0] irq_flag_i,
  input wire logic [IRQ_W-1:0] irq_enable_i,
  input wire logic [IRQ_W-1:0] irq_wake_capable_i,
  input wire wsc_pkg::wsc_ctrl_type ctrl_o,
  input wire logic osc_run_o,
  input wire logic [PORT_W-1:0] port_out_o,
  input wire logic [PORT_W-1:0] port_oe_o,
  input wire logic timeout_status_n_o,
  input wire logic powerdown_status_n_o
);
  // ------------------------------
  // sleep and watchdog relations
  // ------------------------------
  logic wake;
  // any source allowed to wake the core
  assign wake = |(irq_flag_i & irq_enable_i & irq_wake_capable_i);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_SLEEP_STATUS: assert property (
    instr_i.sleep && osc_run_o && !wake
    |-> ##[1:2] (!powerdown_status_n_o && timeout_status_n_o))
    else $error("sleep left status bits wrong");
  AST_OSC_STOP: assert property (
    instr_i.sleep && osc_run_o && !wake |-> ##[1:2] !osc_run_o)
    else $error("oscillator kept running in sleep");
  AST_SLEEP_NOP: assert property (
    instr_i.sleep && osc_run_o && wake && powerdown_status_n_o
    |=> (osc_run_o && powerdown_status_n_o) [*3])
    else $error("sleep with pending irq was not a no-op");
  AST_PORT_HOLD: assert property (
    !osc_run_o && $past(!osc_run_o)
    |-> $stable(port_out_o) && $stable(port_oe_o))
    else $error("port state moved during sleep");
  AST_NO_RESET_ASLEEP: assert property (
    !osc_run_o && $past(!osc_run_o) |-> !ctrl_o.wdt_reset)
    else $error("watchdog reset while asleep");
  AST_WDT_OFF: assert property (
    !device_configuration_word_i[CFG_WATCHDOG_ENABLE_CFG] |-> !ctrl_o.wdt_reset)
    else $error("watchdog reset while disabled");
  AST_TO_CLEAR: assert property (
    ctrl_o.wdt_reset |-> ##[0:2] !timeout_status_n_o)
    else $error("time-out bit not cleared on expiry");
  AST_PD_CAUSE: assert property (
    $fell(powerdown_status_n_o) |-> $past(instr_i.sleep)
    || $past(instr_i.sleep, 2) || $past(instr_i.sleep, 3))
    else $error("power-down bit cleared without sleep");
  AST_IRQ_WAKE: assert property (
    !osc_run_o && $past(!osc_run_o) && wake && master_clear_n_i
    |-> ##[0:12] ctrl_o.resume)
    else $error("enabled irq did not wake the core");
  // main scenarios reached
  cover property (ctrl_o.resume);
  cover property (ctrl_o.wdt_reset);
  cover property ($fell(osc_run_o));
endmodule // wsc_properties

/* tb/wsc_seq_model.sv */
// sequencer and interrupt model facing the controller
// assumes the controller clock and its synchronous reset
`timescale 1ns/1ns
module wsc_seq_model import wsc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sleep_req_i,
  input wire logic clear_req_i,
  input wire logic [11:0] irq_set_i,
  output wsc_pkg::wsc_instr_type instr_o,
  output logic [11:0] irq_flag_o
);
  logic pend_q;
  // ------------------------------
  // instruction pulses and flags
  // ------------------------------
  // a watchdog clear goes out one cycle ahead of every sleep
  // the model keeps no no-op slot after a sleep, it issues whatever is requested next
  always_ff @(posedge clk_i) begin
    instr_o.clear_wdt <= rst_n_i && (clear_req_i || sleep_req_i);
    pend_q <= rst_n_i && sleep_req_i;
    instr_o.sleep <= rst_n_i && pend_q;
  end
  // flags stay set until reset, software never clears them here
  always_ff @(posedge clk_i) begin
    irq_flag_o <= rst_n_i ? (irq_flag_o | irq_set_i) : 12'h000;
  end
endmodule // wsc_seq_model

/* tb/wsc_watchdog_sleep_tb.sv */
// self-checking bench for the watchdog and sleep controller
// assumes the sequencer model and the port checker beside it
`timescale 1ns/1ns
module wsc_watchdog_sleep_tb;
  import wsc_pkg::*;
  logic clk = 0, rst_n = 0, osc = 0, osc_on = 0, master_clear_n_n = 1;
  logic wr = 0, rd = 0, slp = 0, clr = 0;
  logic [7:0] cfg = 8'h01, wdata = 8'h00, pout = 8'hA5, poe = 8'h0F;
  logic [3:0] addr = 4'h0;
  logic [11:0] en = 12'h000, cap = 12'h000, iset = 12'h000, flag;
  logic [7:0] rdata, pout_o, poe_o;
  logic [10:0] vec;
  logic run, to_n, pd_n;
  wsc_instr_type instr;
  wsc_ctrl_type ctrl;
  int n_fail = 0, checked = 0;
  wsc_watchdog_sleep #(.BASE_TICKS(4), .OST_CYCLES(4)) uut (
    .clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .wdt_osc_i(osc),
    .master_clear_n_i(master_clear_n_n), .device_configuration_word_i(cfg),
    .instr_i(instr), .irq_flag_i(flag), .irq_enable_i(en),
    .irq_wake_capable_i(cap), .port_out_i(pout), .port_oe_i(poe),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .ctrl_o(ctrl), .osc_run_o(run),
    .port_out_o(pout_o), .port_oe_o(poe_o), .timeout_status_n_o(to_n),
    .powerdown_status_n_o(pd_n), .vector_o(vec));
  wsc_seq_model seq (.clk_i(clk), .rst_n_i(rst_n), .sleep_req_i(slp),
    .clear_req_i(clr), .irq_set_i(iset), .instr_o(instr),
    .irq_flag_o(flag));
  // ------------------------------
  // clocks and bus tasks
  // ------------------------------
  always #5 clk = ~clk;
  // watchdog oscillator, one tick every three core cycles
  always begin
    repeat (3) @(posedge clk);
    if (osc_on) osc <= ~osc;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task do_rst(input logic [7:0] c);
    @(posedge clk);
    rst_n <= 1'b0;
    cfg <= c;
    osc_on <= 1'b0;
    cyc(3);
    rst_n <= 1'b1;
  endtask
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // bounded wait for resume or, with rs set, watchdog reset
  task wait_ev(input bit rs, input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (!(rs ? ctrl.wdt_reset : ctrl.resume) && c < lim);
  endtask
  task go_sleep;
    @(posedge clk);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    cyc(4);
  endtask
  task irq(input logic [11:0] b);
    @(posedge clk);
    iset <= b;
    @(posedge clk);
    iset <= 12'h000;
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task t_regs;
    logic [7:0] v;
    do_rst(8'h05);
    rd_reg(ADDR_OPTION, v);
    chk(v, 8'hFF);
    wr_reg(ADDR_STATUS, 8'h00);
    wr_reg(ADDR_CONFIG, 8'h00);
    rd_reg(ADDR_STATUS, v);
    chk(v, 8'h18);
    rd_reg(ADDR_CONFIG, v);
    chk(v, 8'h05);
    rd_reg(4'hF, v);
    chk(v, 8'h00);
    wr_reg(ADDR_OPTION, 8'h5A);
    rd_reg(ADDR_OPTION, v);
    chk(v, 8'h5A);
  endtask
  task t_period(input logic [7:0] o, input int d);
    int c;
    do_rst(8'h05);
    wr_reg(ADDR_OPTION, o);
    osc_on <= 1'b1;
    wait_ev(1'b1, 2000, c);
    chk(16'(c >= 12 * d - 3 && c <= 12 * d + 8), 16'h1);
    cyc(1);
    chk(to_n, 1'b0);
  endtask
  task t_clear;
    int c;
    logic [7:0] v;
    do_rst(8'h05);
    wr_reg(ADDR_OPTION, 8'h08);
    osc_on <= 1'b1;
    cyc(18);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wait_ev(1'b1, 200, c);
    chk(16'(c >= 18), 16'h1);
    rd_reg(ADDR_OPTION, v);
    chk(v, 8'h08);
  endtask
  task t_irq;
    int c;
    do_rst(8'h01);
    en <= 12'h020;
    go_sleep;
    chk(pd_n, 1'b0);
    chk(to_n, 1'b1);
    chk(run, 1'b0);
    pout <= 8'h3C;
    poe <= 8'hF0;
    irq(12'h020);
    wait_ev(1'b0, 20, c);
    chk(16'(c), 16'd20);
    chk({pout_o, poe_o}, 16'hA50F);
    master_clear_n_n <= 1'b0;
    cyc(4);
    cap <= 12'h020;
    wait_ev(1'b0, 20, c);
    chk(16'(c), 16'd20);
    master_clear_n_n <= 1'b1;
    wait_ev(1'b0, 20, c);
    chk(16'(c <= 6), 16'h1);
    chk(ctrl.vector, 1'b0);
    wr_reg(ADDR_IRQ, 8'h80);
    cyc(2);
    chk(ctrl.vector, 1'b1);
    chk(vec, 11'h004);
  endtask
  task t_xtal;
    int c;
    do_rst(8'h00);
    en <= 12'h001;
    cap <= 12'h001;
    wr_reg(ADDR_IRQ, 8'h80);
    go_sleep;
    irq(12'h001);
    wait_ev(1'b0, 40, c);
    chk(16'(c >= 5 && c <= 10), 16'h1);
    chk({pd_n, to_n}, 2'b01);
    cyc(1);
    chk(ctrl.vector, 1'b1);
  endtask
  task t_wake;
    int c;
    do_rst(8'h05);
    wr_reg(ADDR_OPTION, 8'h00);
    go_sleep;
    osc_on <= 1'b1;
    wait_ev(1'b0, 100, c);
    chk(16'(c < 100), 16'h1);
    cyc(2);
    chk({to_n, run}, 2'b01);
  endtask
  task t_off;
    int c;
    do_rst(8'h01);
    en <= 12'h002;
    cap <= 12'h002;
    irq(12'h002);
    go_sleep;
    chk({run, pd_n}, 2'b11);
    wr_reg(ADDR_OPTION, 8'h00);
    osc_on <= 1'b1;
    wait_ev(1'b1, 150, c);
    chk(16'(c), 16'd150);
  endtask
  task stop_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    cyc(3);
    rst_n <= 1'b1;
    t_regs;
    t_period(8'h00, 1);
    t_period(8'h08, 2);
    t_period(8'h0A, 8);
    t_period(8'h0E, 128);
    t_clear;
    t_irq;
    t_xtal;
    t_wake;
    t_off;
    stop_test;
  end
  // cut a hang short
  initial begin
    #200000;
    n_fail++;
    stop_test;
  end
endmodule // wsc_watchdog_sleep_tb
bind wsc_watchdog_sleep wsc_properties #(.IRQ_W(IRQ_W), .PORT_W(PORT_W))
  u_props (.clk_i, .rst_n_i, .master_clear_n_i,
  .device_configuration_word_i, .instr_i, .irq_flag_i, .irq_enable_i,
  .irq_wake_capable_i, .ctrl_o, .osc_run_o, .port_out_o, .port_oe_o,
  .timeout_status_n_o, .powerdown_status_n_o);
